// file: logic/ssa_pkg.sv
// Overview of operation
// - Among contending masters at most one holds the grant; the others stay stalled.
// - The winner's address, data and control reach the slave; responses return to it.
// - Every master asserting read or write contends here; there is no address decode.
// - Each master has a configurable share count; each non-burst transfer uses one.
// - Under contention a master keeps the grant for its share count of transfers.
// - A granted master dropping its request forfeits its remaining shares.
// - A master granted anew gets its full configured share count back.
// - The grant passes among contending masters in round-robin order.
// - Only masters requesting at arbitration time are considered; idle ones are skipped.
// - Wait request stays high while a master requests without holding the grant.
// - Once a burst starts no other master reaches the slave until it completes.
// - For a burst the tenure follows the burst length; shares are ignored.
// - Bursts longer than the slave maximum split into maximum bursts plus remainder.
// - Toward a slave without bursts, one single transfer per master beat.
// - The grant stays with a split burst's master until the whole burst ends.
// - One idle cycle precedes each burst issued to the slave.
// - Toward a wrapping slave no issued burst crosses a slave burst boundary.
package ssa_pkg;

    localparam int NUM_M = 2;
    localparam int IDX_W = 1;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int BE_W = 4;
    localparam int BCNT_W = 5;
    localparam int SHARE_W = 4;
    localparam int WORD_LSB = 2;

    localparam logic [ADDR_W-1:0] WORD_BYTES = 32'h0000_0004;
    localparam logic [BCNT_W-1:0] BCNT_ONE = 5'h01;
    localparam logic [BCNT_W-1:0] BCNT_ZERO = 5'h00;
    localparam logic [SHARE_W-1:0] SHARE_ONE = 4'h1;
    localparam logic [SHARE_W-1:0] SHARE_ZERO = 4'h0;

    localparam logic [IDX_W-1:0] RST_LAST_GRANT = 1'h1;
    localparam logic [IDX_W-1:0] RST_GRANT_IDX = 1'h0;
    localparam logic [NUM_M-1:0] RST_GRANT_OH = 2'h0;
    localparam logic [NUM_M-1:0] RST_WAITREQ = 2'h3;
    localparam logic [NUM_M-1:0] RST_READVALID = 2'h0;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'h0,
        ST_GAP = 3'h1,
        ST_LOAD = 3'h2,
        ST_WAIT = 3'h3,
        ST_ACK = 3'h4
    } ssa_state_e;

    typedef struct packed
    {
        logic read;
        logic write;
        logic [ADDR_W-1:0] address;
        logic [DATA_W-1:0] writedata;
        logic [BE_W-1:0] byteenable;
        logic [BCNT_W-1:0] burstcount;
    } ssa_cmd_s;

    function automatic logic [NUM_M-1:0] ssa_onehot(input logic [IDX_W-1:0] idx);
        ssa_onehot = '0;
        ssa_onehot[idx] = 1'b1;
    endfunction : ssa_onehot

endpackage : ssa_pkg

// file: logic/ssa_rr_pick.sv
`timescale 1ns/10ps
`default_nettype none
module ssa_rr_pick
    import ssa_pkg::*;
(
    input wire logic [NUM_M-1:0] req,
    input wire logic [IDX_W-1:0] last,
    output logic valid,
    output logic [IDX_W-1:0] idx
);

    // Search starts just after the last winner; nearest requester wins
    always_comb
    begin
        logic [IDX_W-1:0] cand;
        cand = '0;
        valid = 1'b0;
        idx = last;
        for (int k = NUM_M; k >= 1; k--)
        begin
            cand = IDX_W'((int'(last) + k) % NUM_M);
            if (req[cand])
            begin
                valid = 1'b1;
                idx = cand;
            end
        end
    end

endmodule : ssa_rr_pick
`default_nettype wire

// file: logic/ssa_seg_calc.sv
`timescale 1ns/10ps
`default_nettype none
module ssa_seg_calc
    import ssa_pkg::*;
(
    input wire logic [BCNT_W-1:0] totalLeft,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [BCNT_W-1:0] maxLen,
    input wire logic burstEn,
    input wire logic wrapEn,
    output logic [BCNT_W-1:0] segLen
);

    // Wrap boundary arithmetic assumes a power-of-two slave maximum
    always_comb
    begin
        logic [BCNT_W-1:0] lim;
        logic [BCNT_W-1:0] offs;
        logic [BCNT_W-1:0] toBnd;
        lim = (maxLen == BCNT_ZERO) ? BCNT_ONE : maxLen;
        offs = addr[WORD_LSB +: BCNT_W] & (lim - BCNT_ONE);
        toBnd = lim - offs;
        if (wrapEn && (toBnd < lim))
        begin
            lim = toBnd;
        end
        if (!burstEn || (totalLeft == BCNT_ZERO))
        begin
            segLen = BCNT_ONE;
        end
        else if (totalLeft > lim)
        begin
            segLen = lim;
        end
        else
        begin
            segLen = totalLeft;
        end
    end

endmodule : ssa_seg_calc
`default_nettype wire

// file: logic/ssa_arbiter.sv
`timescale 1ns/10ps
`default_nettype none
module ssa_arbiter
    import ssa_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire ssa_cmd_s [NUM_M-1:0] mCmd,
    output logic [NUM_M-1:0] mWaitReq_ff,
    output logic [DATA_W-1:0] mReadData_ff,
    output logic [NUM_M-1:0] mReadValid_ff,
    output ssa_cmd_s sCmd_ff,
    input wire logic sWaitReq,
    input wire logic [DATA_W-1:0] sReadData,
    input wire logic sReadValid,
    input wire logic [NUM_M-1:0][SHARE_W-1:0] shareCount,
    input wire logic [BCNT_W-1:0] slaveMaxBurst,
    input wire logic slaveBurstEn,
    input wire logic wrappingBurstFlag,
    output logic [NUM_M-1:0] grantOh_ff,
    output logic burstBusy_ff
);

    logic [NUM_M-1:0] mReq;
    ssa_state_e state_ff;
    ssa_state_e nxt_state;
    logic [IDX_W-1:0] grantIdx_ff;
    logic [IDX_W-1:0] lastGrant_ff;
    logic [IDX_W-1:0] readOwner_ff;
    logic [IDX_W-1:0] pickIdx;
    logic pickValid;
    logic burstMode_ff;
    logic segStart_ff;
    logic [BCNT_W-1:0] totalLeft_ff;
    logic [BCNT_W-1:0] segLeft_ff;
    logic [BCNT_W-1:0] segLen;
    logic [BCNT_W-1:0] pickCount;
    logic [SHARE_W-1:0] shareLeft_ff;
    logic [SHARE_W-1:0] pickShare;
    logic [ADDR_W-1:0] curAddr_ff;
    logic accept;
    logic startGrant;
    logic startBurst;
    logic release_;
    logic reseg;
    ssa_cmd_s gCmd;

    // Every master asserting read or write requests here; no address is decoded
    genvar gi;
    for (gi = 0; gi < NUM_M; gi++)
    begin : g_req
        assign mReq[gi] = mCmd[gi].read | mCmd[gi].write;
    end

    assign gCmd = mCmd[grantIdx_ff];
    assign accept = (state_ff == ST_WAIT) && !sWaitReq;
    assign startGrant = (state_ff == ST_IDLE) && pickValid;
    // Burst length is taken with the first beat
    assign pickCount = (mCmd[pickIdx].burstcount == BCNT_ZERO) ? BCNT_ONE : mCmd[pickIdx].burstcount;
    assign pickShare = (shareCount[pickIdx] == SHARE_ZERO) ? SHARE_ONE : shareCount[pickIdx];
    assign startBurst = pickCount > BCNT_ONE;
    assign release_ = (state_ff != ST_IDLE) && (nxt_state == ST_IDLE);
    // Non-burst slave: each beat is its own single transfer
    assign reseg = (state_ff == ST_ACK) && burstMode_ff && (segLeft_ff == BCNT_ZERO)
                   && (totalLeft_ff != BCNT_ZERO) && !slaveBurstEn;

    ssa_rr_pick u_pick
    (
        .req(mReq),
        .last(lastGrant_ff),
        .valid(pickValid),
        .idx(pickIdx)
    );

    ssa_seg_calc u_seg
    (
        .totalLeft(totalLeft_ff),
        .addr(curAddr_ff),
        .maxLen(slaveMaxBurst),
        .burstEn(slaveBurstEn),
        .wrapEn(wrappingBurstFlag),
        .segLen(segLen)
    );

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE:
            begin
                if (pickValid)
                begin
                    nxt_state = startBurst ? ST_GAP : ST_LOAD;
                end
            end
            ST_GAP:
            begin
                nxt_state = ST_LOAD;
            end
            ST_LOAD:
            begin
                if (!mReq[grantIdx_ff])
                begin
                    nxt_state = burstMode_ff ? ST_LOAD : ST_IDLE;
                end
                else
                begin
                    nxt_state = ST_WAIT;
                end
            end
            ST_WAIT:
            begin
                if (!sWaitReq)
                begin
                    nxt_state = ST_ACK;
                end
            end
            ST_ACK:
            begin
                if (burstMode_ff)
                begin
                    if (totalLeft_ff == BCNT_ZERO)
                    begin
                        nxt_state = ST_IDLE;
                    end
                    else if ((segLeft_ff == BCNT_ZERO) && slaveBurstEn)
                    begin
                        nxt_state = ST_GAP;
                    end
                    else
                    begin
                        nxt_state = ST_LOAD;
                    end
                end
                else
                begin
                    nxt_state = (shareLeft_ff == SHARE_ZERO) ? ST_IDLE : ST_LOAD;
                end
            end
            default:
            begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_ff <= ST_IDLE;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // Grant and rotation pointer
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            grantIdx_ff <= RST_GRANT_IDX;
            lastGrant_ff <= RST_LAST_GRANT;
            grantOh_ff <= RST_GRANT_OH;
            burstBusy_ff <= 1'b0;
        end
        else if (startGrant)
        begin
            grantIdx_ff <= pickIdx;
            lastGrant_ff <= pickIdx;
            grantOh_ff <= ssa_onehot(pickIdx);
            burstBusy_ff <= startBurst;
        end
        else if (release_)
        begin
            grantOh_ff <= RST_GRANT_OH;
            burstBusy_ff <= 1'b0;
        end
    end

    // Beat, segment and share bookkeeping
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            burstMode_ff <= 1'b0;
            totalLeft_ff <= BCNT_ZERO;
            segLeft_ff <= BCNT_ZERO;
            shareLeft_ff <= SHARE_ZERO;
            curAddr_ff <= '0;
            segStart_ff <= 1'b0;
        end
        else if (startGrant)
        begin
            burstMode_ff <= startBurst;
            totalLeft_ff <= pickCount;
            segLeft_ff <= BCNT_ONE;
            shareLeft_ff <= pickShare;
            curAddr_ff <= mCmd[pickIdx].address;
            segStart_ff <= 1'b1;
        end
        else if ((state_ff == ST_GAP) || reseg)
        begin
            segLeft_ff <= segLen;
            segStart_ff <= 1'b1;
        end
        else if (accept)
        begin
            totalLeft_ff <= totalLeft_ff - BCNT_ONE;
            segLeft_ff <= segLeft_ff - BCNT_ONE;
            shareLeft_ff <= burstMode_ff ? shareLeft_ff : shareLeft_ff - SHARE_ONE;
            curAddr_ff <= curAddr_ff + WORD_BYTES;
            segStart_ff <= 1'b0;
        end
    end

    // Slave command register
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sCmd_ff <= '0;
        end
        else if ((state_ff == ST_LOAD) && mReq[grantIdx_ff])
        begin
            sCmd_ff.read <= gCmd.read;
            sCmd_ff.write <= gCmd.write;
            sCmd_ff.address <= burstMode_ff ? curAddr_ff : gCmd.address;
            sCmd_ff.writedata <= gCmd.writedata;
            sCmd_ff.byteenable <= gCmd.byteenable;
            if (!burstMode_ff)
            begin
                sCmd_ff.burstcount <= BCNT_ONE;
            end
            else if (segStart_ff)
            begin
                sCmd_ff.burstcount <= segLeft_ff;
            end
        end
        else if (accept)
        begin
            sCmd_ff.read <= 1'b0;
            sCmd_ff.write <= 1'b0;
        end
    end

    // Wait request is released for one cycle once the slave takes the beat
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            mWaitReq_ff <= RST_WAITREQ;
        end
        else if (accept)
        begin
            mWaitReq_ff <= ~ssa_onehot(grantIdx_ff);
        end
        else
        begin
            mWaitReq_ff <= RST_WAITREQ;
        end
    end

    // Read responses go back to the master that issued the read
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            readOwner_ff <= RST_GRANT_IDX;
            mReadData_ff <= '0;
            mReadValid_ff <= RST_READVALID;
        end
        else
        begin
            if (accept && sCmd_ff.read)
            begin
                readOwner_ff <= grantIdx_ff;
            end
            mReadData_ff <= sReadData;
            mReadValid_ff <= sReadValid ? ssa_onehot(readOwner_ff) : RST_READVALID;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_accept;
        (state_ff == ST_WAIT) && !sWaitReq;
    endsequence

    sequence s_beat_ack;
        s_accept ##1 (state_ff == ST_ACK);
    endsequence

    a_grant_single: assert property ($onehot0(grantOh_ff))
        else $error("more than one master granted");

    a_stall_losers: assert property ((mReq & ~grantOh_ff & ~mWaitReq_ff) == RST_GRANT_OH)
        else $error("requesting master without grant was not stalled");

    a_beat_ack: assert property (s_beat_ack |-> !mWaitReq_ff[grantIdx_ff] && $onehot(~mWaitReq_ff))
        else $error("accepted beat not acknowledged to the granted master");

    a_write_mux: assert property ($rose(sCmd_ff.write) |-> sCmd_ff.writedata == $past(gCmd.writedata))
        else $error("slave write data not from granted master");

    a_forfeit_drop: assert property ((state_ff == ST_LOAD) && !burstMode_ff && !mReq[grantIdx_ff]
        |=> (state_ff == ST_IDLE) && (grantOh_ff == RST_GRANT_OH))
        else $error("dropped request did not forfeit the grant");

    a_share_reload: assert property (startGrant |=> shareLeft_ff == $past(pickShare))
        else $error("share count not reloaded on new grant");

    a_share_limit: assert property ((state_ff == ST_ACK) && !burstMode_ff && (shareLeft_ff == SHARE_ZERO)
        |=> state_ff == ST_IDLE)
        else $error("grant kept after shares were used up");

    a_burst_hold: assert property (burstMode_ff && (state_ff != ST_IDLE) && (totalLeft_ff != BCNT_ZERO)
        |=> $stable(grantIdx_ff) && (state_ff != ST_IDLE))
        else $error("burst lost its grant before completion");

    a_gap_first: assert property (startGrant && startBurst
        |=> (state_ff == ST_GAP) && !sCmd_ff.read && !sCmd_ff.write ##1 state_ff == ST_LOAD)
        else $error("no idle cycle before slave burst");

    a_seg_size: assert property ((sCmd_ff.read || sCmd_ff.write)
        |-> (slaveBurstEn ? (sCmd_ff.burstcount <= slaveMaxBurst) : (sCmd_ff.burstcount == BCNT_ONE)))
        else $error("slave burst longer than slave allows");

    a_reset_clear: assert property (@(posedge clk) disable iff (1'b0)
        rst |=> (grantOh_ff == RST_GRANT_OH) && (state_ff == ST_IDLE) && (lastGrant_ff == RST_LAST_GRANT))
        else $error("reset did not clear grant state");

endmodule : ssa_arbiter
`default_nettype wire

// file: sim/ssa_slave_model.sv
`timescale 1ns/10ps
`default_nettype none
module ssa_slave_model
    import ssa_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire ssa_cmd_s sCmd,
    input wire logic slow,
    output logic sWaitReq,
    output logic [DATA_W-1:0] sReadData,
    output logic sReadValid
);
    logic [7:0] lfsr_ff;
    logic [DATA_W-1:0] rdData_ff;
    logic rdValid_ff;

    // Pseudo-random stalls, only in slow mode
    always_ff @(posedge clk)
    begin
        if (rst)
            lfsr_ff <= 8'h5a;
        else
            lfsr_ff <= {lfsr_ff[6:0], lfsr_ff[7] ^ lfsr_ff[5] ^ lfsr_ff[4] ^ lfsr_ff[3]};
    end

    assign sWaitReq = slow & lfsr_ff[0];

    // Data a cycle after accept; toggles otherwise so stale data never matches
    always_ff @(posedge clk)
    begin
        rdValid_ff <= sCmd.read & ~sWaitReq & ~rst;
        if (rst)
            rdData_ff <= 32'h0;
        else if (sCmd.read & ~sWaitReq)
            rdData_ff <= ~sCmd.address;
        else
            rdData_ff <= ~rdData_ff;
    end

    assign sReadValid = rdValid_ff;
    assign sReadData = rdData_ff;
endmodule : ssa_slave_model
`default_nettype wire

// file: sim/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb
    import ssa_pkg::*;
;
    typedef struct packed
    {
        logic [IDX_W-1:0] m;
        logic [ADDR_W-1:0] a;
        logic [DATA_W-1:0] d;
        logic [BCNT_W-1:0] bc;
        logic rd;
        logic bu;
    } ssa_exp_s;

    logic clk = 1'b0;
    logic rst = 1'b1;
    ssa_cmd_s [NUM_M-1:0] mCmd = '0;
    logic [NUM_M-1:0][SHARE_W-1:0] shares = {4'h4, 4'h3};
    logic burstEn = 1'b1;
    logic [BCNT_W-1:0] maxLen = 5'h08;
    logic wrapFlag = 1'b0;
    logic slow = 1'b0;
    logic [NUM_M-1:0] mWaitReq;
    logic [DATA_W-1:0] mReadData;
    logic [NUM_M-1:0] mReadValid;
    ssa_cmd_s sCmd;
    logic sWaitReq;
    logic [DATA_W-1:0] sReadData;
    logic sReadValid;
    logic [NUM_M-1:0] grant;
    logic busy;
    ssa_exp_s expQ[$];
    ssa_exp_s rdQ[$];
    int num_errors = 0;
    int n_compared = 0;
    int seed = 43;
    logic [15:0] salt = 16'h0;

    always #2.5 clk = ~clk;

    ssa_arbiter dut_u (.clk(clk), .rst(rst), .mCmd(mCmd), .mWaitReq_ff(mWaitReq), .mReadData_ff(mReadData),
        .mReadValid_ff(mReadValid), .sCmd_ff(sCmd), .sWaitReq(sWaitReq), .sReadData(sReadData),
        .sReadValid(sReadValid), .shareCount(shares), .slaveMaxBurst(maxLen), .slaveBurstEn(burstEn),
        .wrappingBurstFlag(wrapFlag), .grantOh_ff(grant), .burstBusy_ff(busy));

    ssa_slave_model slv_u (.clk(clk), .rst(rst), .sCmd(sCmd), .slow(slow), .sWaitReq(sWaitReq),
        .sReadData(sReadData), .sReadValid(sReadValid));

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : test_done

    task automatic timed_out(input string what);
        num_errors++;
        $display("[ERR] %s expected done seen hang", what);
        test_done();
    endtask : timed_out

    function automatic logic [DATA_W-1:0] beatData(input int m, input int k);
        beatData = {salt, m[7:0], k[7:0]};
    endfunction : beatData

    task automatic expPush(input int m, input logic [ADDR_W-1:0] a, input int k, input logic rd,
        input logic [BCNT_W-1:0] bc, input logic bu);
        expQ.push_back('{m[IDX_W-1:0], a, beatData(m, k), bc, rd, bu});
        if (rd)
            rdQ.push_back('{m[IDX_W-1:0], a, ~a, bc, rd, bu});
    endtask : expPush

    task automatic expShare(input int m, input int k0, input int n, input logic [ADDR_W-1:0] a0);
        for (int k = k0; k < k0 + n; k++)
            expPush(m, a0 + 4 * k, k, 1'b0, 5'h01, 1'b0);
    endtask : expShare

    // Slave-side segments of one master burst, slave maximum mx
    task automatic expBurst(input int m, input int n, input logic [ADDR_W-1:0] a0, input logic rd,
        input logic be, input logic wr, input int mx);
        int k;
        int seg;
        int lim;
        k = 0;
        while (k < n)
        begin
            seg = be ? n - k : 1;
            if (seg > mx)
                seg = mx;
            lim = mx - ((a0 >> 2) + k) % mx;
            if (wr && seg > lim)
                seg = lim;
            repeat (seg)
            begin
                expPush(m, a0 + 4 * k, k, rd, seg[BCNT_W-1:0], 1'b1);
                k++;
            end
        end
    endtask : expBurst

    // Master beats, with a one-cycle request drop after beat gapAt
    task automatic mrun(input int m, input int n, input int gapAt, input logic [BCNT_W-1:0] bl,
        input logic [ADDR_W-1:0] a0, input logic rd);
        int t;
        @(posedge clk);
        for (int k = 0; k < n; k++)
        begin
            mCmd[m] <= '{rd, !rd, a0 + 4 * k, beatData(m, k), salt[3:0], bl};
            t = 0;
            do
            begin
                @(posedge clk);
                t++;
            end
            while (mWaitReq[m] !== 1'b0 && t < 300);
            if (t >= 300)
                timed_out("master wait");
            if (k == gapAt)
            begin
                mCmd[m] <= '0;
                @(posedge clk);
            end
        end
        mCmd[m] <= '0;
    endtask : mrun

    task automatic drain();
        int t;
        t = 0;
        while ((expQ.size() != 0 || rdQ.size() != 0) && t < 2000)
        begin
            @(posedge clk);
            t++;
        end
        if (t >= 2000)
            timed_out("result drain");
        repeat (3) @(posedge clk);
    endtask : drain

    // Every accepted slave beat and returned read against the oldest note
    always @(posedge clk)
    begin
        ssa_exp_s e;
        if (!rst && (sCmd.read | sCmd.write) === 1'b1 && sWaitReq === 1'b0)
        begin
            if (expQ.size() == 0)
                chk("spare slave beat", 32'h1, 32'h0);
            else
            begin
                e = expQ.pop_front();
                chk("slave address", sCmd.address, e.a);
                chk("slave data", sCmd.writedata, e.d);
                chk("slave burstcount", 32'(sCmd.burstcount), 32'(e.bc));
                chk("grant", 32'(grant), 32'h1 << e.m);
                chk("slave read", 32'(sCmd.read), 32'(e.rd));
                chk("slave byteenable", 32'(sCmd.byteenable), 32'(salt[3:0]));
                chk("burst busy", 32'(busy), 32'(e.bu));
            end
        end
        if (!rst && mReadValid !== 2'h0)
        begin
            if (rdQ.size() == 0)
                chk("spare read", 32'h1, 32'h0);
            else
            begin
                e = rdQ.pop_front();
                chk("read data", mReadData, e.d);
                chk("read target", 32'(mReadValid), 32'h1 << e.m);
            end
        end
        for (int i = 0; i < NUM_M; i++)
            if (!rst && mWaitReq[i] === 1'b0)
                chk("wait low without grant", 32'(grant[i]), 32'h1);
    end

    initial
    begin
        int cLen[6] = '{16, 14, 16, 8, 8, 14};
        logic cBurst[6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
        logic cWrap[6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
        logic cRd[6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
        logic [ADDR_W-1:0] cAddr[6] = '{32'h1000, 32'h1100, 32'h1200, 32'hc, 32'h0, 32'h1300};
        logic [BCNT_W-1:0] cMax[6] = '{5'h08, 5'h08, 5'h08, 5'h08, 5'h08, 5'h04};
        int m;
        salt = 16'($random(seed));
        cAddr[4] = 32'($random(seed)) & 32'h3c;
        repeat (8) @(posedge clk);
        chk("reset wait", 32'(mWaitReq), 32'h3);
        chk("reset grant", 32'(grant), 32'h0);
        chk("reset busy", 32'(busy), 32'h0);
        chk("reset slave cmd", 32'(sCmd.read | sCmd.write), 32'h0);
        rst <= 1'b0;
        slow <= 1'b1;
        // Continuous contention, three then four shares
        expShare(0, 0, 3, 32'h1000);
        expShare(1, 0, 4, 32'h2000);
        expShare(0, 3, 3, 32'h1000);
        expShare(1, 4, 4, 32'h2000);
        fork
            mrun(0, 6, -1, 5'h01, 32'h1000, 1'b0);
            mrun(1, 8, -1, 5'h01, 32'h2000, 1'b0);
        join
        drain();
        // Second reset, then a one-cycle drop forfeits the rest of the shares
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        chk("reset grant", 32'(grant), 32'h0);
        chk("reset wait", 32'(mWaitReq), 32'h3);
        rst <= 1'b0;
        expShare(0, 0, 1, 32'h1000);
        expShare(1, 0, 4, 32'h2000);
        expShare(0, 1, 3, 32'h1000);
        expShare(1, 4, 4, 32'h2000);
        fork
            mrun(0, 4, 0, 5'h01, 32'h1000, 1'b0);
            mrun(1, 8, -1, 5'h01, 32'h2000, 1'b0);
        join
        drain();
        // Bursts with the other master contending from the third cycle
        for (int c = 0; c < 6; c++)
        begin
            m = c % 2;
            burstEn <= cBurst[c];
            wrapFlag <= cWrap[c];
            maxLen <= cMax[c];
            expBurst(m, cLen[c], cAddr[c], cRd[c], cBurst[c], cWrap[c], int'(cMax[c]));
            expPush(1 - m, 32'h3000, 0, 1'b0, 5'h01, 1'b0);
            fork
                mrun(m, cLen[c], -1, cLen[c][BCNT_W-1:0], cAddr[c], cRd[c]);
                begin
                    repeat (2) @(posedge clk);
                    mrun(1 - m, 1, -1, 5'h01, 32'h3000, 1'b0);
                end
            join
            drain();
        end
        test_done();
    end
endmodule : tb
`default_nettype wire
